/* File: src/upw_map.vh */
`ifndef UPW_MAP_VH
`define UPW_MAP_VH
// ==========================================
// register indexes on the plain port
`define UPW_A_CTRL 5'h00
`define UPW_A_GIDX 5'h01
`define UPW_A_PICK 5'h02
`define UPW_A_INH 5'h03
`define UPW_A_TDLY 5'h04
`define UPW_A_RDLY 5'h05
`define UPW_A_STAT 5'h06
`define UPW_A_EXPT 5'h07
`define UPW_A_REMT 5'h08
`define UPW_A_RATIO 5'h09
`define UPW_A_CSTA 5'h0a
`define UPW_A_CTRP 5'h0b
`define UPW_A_CBLK 5'h0c
`define UPW_A_CCLR 5'h0d
`define UPW_A_PREF 5'h0e
`define UPW_A_TIME 5'h0f
`define UPW_A_RIDX 5'h10
`define UPW_A_RSTMP 5'h11
`define UPW_A_RPWR 5'h12
`define UPW_A_RPRE 5'h13
// ==========================================
// control fields
`define UPW_C_TIMED 0
`define UPW_C_FEN 1
`define UPW_C_SWBLK 2
`define UPW_C_MSIDE 3
`define UPW_C_FST_LO 4
`define UPW_C_FST_HI 5
`define UPW_CTRL_RST 32'h00000001
// ==========================================
// settings defaults, power in 0.01 kW units
`define UPW_PICK_RST 24'h002710
`define UPW_INH_RST 24'h001388
`define UPW_TDLY_RST 16'h0014
`define UPW_RDLY_RST 16'h0000
// ==========================================
// condition codes
`define UPW_CND_NORM 2'h0
`define UPW_CND_START 2'h1
`define UPW_CND_TRIP 2'h2
`define UPW_CND_BLK 2'h3
// ==========================================
// timing
`define UPW_CLK_NS 100
`define UPW_MS_NS 1000000
`define UPW_CYCLE_MS 5
`define UPW_RELEASE_PCT 103
`define UPW_REC_DEPTH 12
`endif

/* File: src/upw_stage.v */
`timescale 1ns/1ns
// Contract
// (R1) eight setting groups, common group select
// (R2) instant or delayed; instant: same stamp
// (R3) start, trip, blocked with on/off events
// (R4) event stamps in one millisecond steps
// (R5) clearable counters for start, trip, blocked
// (R6) total active power sampled every 5 ms
// (R7) 20 ms averaged power kept as pre-fault
// (R8) measured side setting picks current input
// (R9) force status, only with forcing enabled
// (R10) pick-up setting, release above 103 percent
// (R11) low-power inhibit until power above 1.03x
// (R12) start needs pick-up and no blocking
// (R13) blocking sampled at each program cycle
// (R14) unblocked pick-up starts, then trip timing
// (R15) blocked pick-up gives blocked, nothing more
// (R16) block during start: release as reset
// (R17) blocking raises display event with power
// (R18) software block switch under forcing
// (R19) blocker asserts 5 ms before delay ends; not implemented, no output asserts ahead of trip
// (R20) definite time only for trip and reset
// (R21) condition, expected time, ratio in 5 ms
// (R22) report time remaining while counting
// (R23) twelve records of on-event data
// (R24) pick-up means power below setting
// (R25) trip after delay, clear on release
`include "upw_map.vh"
module upw_stage #(
  parameter MS_CYC = `UPW_MS_NS / `UPW_CLK_NS,
  parameter PROG_CYC = `UPW_CYCLE_MS * (`UPW_MS_NS / `UPW_CLK_NS)
) (
  input wire clock,
  input wire srst,
  input wire [4:0] addr,
  input wire [31:0] wrData,
  input wire wrStb,
  input wire rdStb,
  output reg [31:0] rdData,
  input wire [23:0] measuredPower,
  input wire [2:0] activeGroup,
  input wire blockIn,
  output reg measSide,
  output reg startOut,
  output reg tripOut,
  output reg blockedOut,
  output reg [2:0] evOn,
  output reg [2:0] evOff,
  output reg [31:0] evStamp,
  output reg [23:0] evPower,
  output reg displayEvent
);
  // ==========================================
  // state codes
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_RUN = 5'b00010;
  localparam [4:0] S_TRIP = 5'b00100;
  localparam [4:0] S_REL = 5'b01000;
  localparam [4:0] S_BLK = 5'b10000;

  function [31:0] cntNext;
    input [31:0] c;
    input clr;
    input inc;
    begin
      // an occurrence in the clear cycle still counts
      cntNext = (clr ? 32'h00000000 : c) + {31'h00000000, inc};
    end
  endfunction

  // ==========================================
  // settings
  reg [31:0] ctrl_q;
  reg [2:0] gIdx_q;
  reg [23:0] pickMem [0:7];
  reg [23:0] inhMem [0:7];
  reg [15:0] tDlyMem [0:7];
  reg [15:0] rDlyMem [0:7];
  integer i;
  integer j;
  integer k;

  wire forceEn = ctrl_q[`UPW_C_FEN];
  wire [1:0] forceSt = ctrl_q[`UPW_C_FST_HI:`UPW_C_FST_LO];
  wire [23:0] power_pickup_threshold = pickMem[activeGroup]; // R1
  wire [23:0] inhSet = inhMem[activeGroup]; // R1
  wire [15:0] tDly = tDlyMem[activeGroup]; // R20
  wire [15:0] rDly = rDlyMem[activeGroup]; // R20

  always @(posedge clock) begin
    if (srst) begin
      ctrl_q <= `UPW_CTRL_RST;
      gIdx_q <= 3'h0;
      for (i = 0; i < 8; i = i + 1) begin
        pickMem[i] <= `UPW_PICK_RST;
        inhMem[i] <= `UPW_INH_RST;
        tDlyMem[i] <= `UPW_TDLY_RST;
        rDlyMem[i] <= `UPW_RDLY_RST;
      end
    end else if (wrStb) begin
      if (addr == `UPW_A_CTRL) begin
        ctrl_q <= {26'h0000000, wrData[5:0]};
      end else if (addr == `UPW_A_GIDX) begin
        gIdx_q <= wrData[2:0];
      end else if (addr == `UPW_A_PICK) begin
        pickMem[gIdx_q] <= wrData[23:0];
      end else if (addr == `UPW_A_INH) begin
        inhMem[gIdx_q] <= wrData[23:0];
      end else if (addr == `UPW_A_TDLY) begin
        tDlyMem[gIdx_q] <= wrData[15:0];
      end else if (addr == `UPW_A_RDLY) begin
        rDlyMem[gIdx_q] <= wrData[15:0];
      end
    end
  end

  // ==========================================
  // millisecond time base and program cycle
  reg [31:0] msCnt_q;
  reg [31:0] msDiv_q;
  reg [31:0] progDiv_q;
  wire progTick = (progDiv_q == PROG_CYC - 1);

  always @(posedge clock) begin
    if (srst) begin
      msCnt_q <= 32'h00000000;
      msDiv_q <= 32'h00000000;
      progDiv_q <= 32'h00000000;
    end else begin
      if (msDiv_q == MS_CYC - 1) begin
        msDiv_q <= 32'h00000000;
        msCnt_q <= msCnt_q + 32'h00000001; // R4
      end else begin
        msDiv_q <= msDiv_q + 32'h00000001;
      end
      progDiv_q <= progTick ? 32'h00000000 : progDiv_q + 32'h00000001; // R6
    end
  end

  // ==========================================
  // comparator and pre-fault average
  reg [23:0] pwr_q;
  reg [23:0] hist_q [0:3];
  reg picked_q;
  reg inhAct_q;
  reg blk_q;
  wire [31:0] pwr100 = {8'h00, measuredPower} * 32'd100;
  wire [31:0] rel = {8'h00, power_pickup_threshold} * `UPW_RELEASE_PCT;
  wire above = pwr100 > rel; // R10
  wire below = measuredPower < power_pickup_threshold; // R24
  wire [25:0] histSum = {2'h0, hist_q[0]} + {2'h0, hist_q[1]}
    + {2'h0, hist_q[2]} + {2'h0, hist_q[3]};
  wire [23:0] preAvg = histSum[25:2]; // R7
  // software switch only counts while forcing is on
  wire blkNow = blockIn | (forceEn & ctrl_q[`UPW_C_SWBLK]); // R13 R18

  always @(posedge clock) begin
    if (srst) begin
      pwr_q <= 24'h000000;
      picked_q <= 1'b0;
      inhAct_q <= 1'b1;
      blk_q <= 1'b0;
      for (j = 0; j < 4; j = j + 1) begin
        hist_q[j] <= 24'h000000;
      end
    end else if (progTick) begin
      pwr_q <= measuredPower; // R6
      hist_q[0] <= measuredPower;
      for (j = 1; j < 4; j = j + 1) begin
        hist_q[j] <= hist_q[j - 1];
      end
      picked_q <= picked_q ? !above : below; // R10
      if (above) begin
        inhAct_q <= 1'b0; // R11
      end else if (measuredPower < inhSet) begin
        inhAct_q <= 1'b1; // R11
      end
      blk_q <= blkNow; // R13
    end
  end

  // ==========================================
  // stage sequencer, advances once per program cycle
  reg [4:0] st_q;
  reg [4:0] st_d;
  reg [15:0] tCnt_q;
  reg [15:0] tCnt_d;
  reg [23:0] startPwr_q;
  wire pu = picked_q & !inhAct_q; // R11
  wire instant = !ctrl_q[`UPW_C_TIMED];

  always @* begin
    st_d = st_q;
    tCnt_d = tCnt_q;
    case (st_q)
      S_IDLE: begin
        tCnt_d = 16'h0000;
        if (pu && blk_q) begin
          st_d = S_BLK; // R15
        end else if (pu) begin
          st_d = instant ? S_TRIP : S_RUN; // R2 R12 R14
        end
      end
      S_RUN: begin
        if (!pu || blk_q) begin
          st_d = S_REL; // R16
          tCnt_d = 16'h0000;
        end else if (tCnt_q + 16'h0001 >= tDly) begin
          st_d = S_TRIP; // R25
        end else begin
          tCnt_d = tCnt_q + 16'h0001;
        end
      end
      S_TRIP: begin
        if (!pu || blk_q) begin
          st_d = S_REL; // R25
          tCnt_d = 16'h0000;
        end
      end
      S_REL: begin
        if (pu && !blk_q) begin
          st_d = S_RUN;
        end else if (tCnt_q >= rDly) begin
          st_d = (pu && blk_q) ? S_BLK : S_IDLE; // R16 R20
          tCnt_d = 16'h0000;
        end else begin
          tCnt_d = tCnt_q + 16'h0001;
        end
      end
      S_BLK: begin
        if (!pu || !blk_q) begin
          st_d = S_IDLE;
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
  end

  // forced start, trip or blocked status overrides outputs, events, counters and records, not the sequencer state
  reg [2:0] out_d;
  always @* begin
    out_d = {st_q == S_BLK, st_q == S_TRIP,
      (st_q == S_RUN) | (st_q == S_TRIP) | (st_q == S_REL)}; // R3 R12
    if (forceEn) begin
      case (forceSt)
        `UPW_CND_START: out_d = 3'b001; // R9
        `UPW_CND_TRIP: out_d = 3'b011; // R9
        `UPW_CND_BLK: out_d = 3'b100; // R9
        default: out_d = out_d;
      endcase
    end
  end

  reg [2:0] outPrev_q;
  reg [31:0] cSta_q;
  reg [31:0] cTrp_q;
  reg [31:0] cBlk_q;
  wire [2:0] rise = out_d & ~outPrev_q;
  wire [2:0] fall = ~out_d & outPrev_q;
  wire [2:0] clrReq = (wrStb && addr == `UPW_A_CCLR) ? wrData[2:0] : 3'h0;
  wire evAny = progTick & (|rise | |fall);

  always @(posedge clock) begin
    if (srst) begin
      st_q <= S_IDLE;
      tCnt_q <= 16'h0000;
      startPwr_q <= 24'h000000;
      outPrev_q <= 3'h0;
      startOut <= 1'b0;
      tripOut <= 1'b0;
      blockedOut <= 1'b0;
      evOn <= 3'h0;
      evOff <= 3'h0;
      evStamp <= 32'h00000000;
      evPower <= 24'h000000;
      displayEvent <= 1'b0;
      measSide <= 1'b0;
    end else begin
      measSide <= ctrl_q[`UPW_C_MSIDE]; // R8
      evOn <= progTick ? rise : 3'h0; // R3
      evOff <= progTick ? fall : 3'h0; // R3
      displayEvent <= progTick & rise[2]; // R17
      if (evAny) begin
        // one stamp for every edge of the cycle
        evStamp <= msCnt_q; // R2 R4
        evPower <= rise[2] ? startPwr_q : pwr_q; // R17
      end
      if (progTick) begin
        st_q <= st_d;
        tCnt_q <= tCnt_d;
        outPrev_q <= out_d;
        {blockedOut, tripOut, startOut} <= out_d;
        if (st_q == S_IDLE) begin
          startPwr_q <= pwr_q;
        end
      end
    end
  end

  // ==========================================
  // counters, write 1 to clear
  always @(posedge clock) begin
    if (srst) begin
      cSta_q <= 32'h00000000;
      cTrp_q <= 32'h00000000;
      cBlk_q <= 32'h00000000;
    end else begin
      cSta_q <= cntNext(cSta_q, clrReq[0], progTick & rise[0]); // R5
      cTrp_q <= cntNext(cTrp_q, clrReq[1], progTick & rise[1]); // R5
      cBlk_q <= cntNext(cBlk_q, clrReq[2], progTick & rise[2]); // R5
    end
  end

  // ==========================================
  // operation records
  reg [2:0] recCode [0:11];
  reg [31:0] recStamp [0:11];
  reg [23:0] recPwr [0:11];
  reg [23:0] recPre [0:11];
  reg [3:0] recPtr_q;
  reg [3:0] recIdx_q;

  always @(posedge clock) begin
    if (srst) begin
      recPtr_q <= 4'h0;
      recIdx_q <= 4'h0;
      for (k = 0; k < `UPW_REC_DEPTH; k = k + 1) begin
        recCode[k] <= 3'h0;
        recStamp[k] <= 32'h00000000;
        recPwr[k] <= 24'h000000;
        recPre[k] <= 24'h000000;
      end
    end else begin
      if (wrStb && addr == `UPW_A_RIDX && wrData[3:0] < `UPW_REC_DEPTH) begin
        recIdx_q <= wrData[3:0];
      end
      if (progTick && |rise) begin
        recCode[recPtr_q] <= rise; // R23
        recStamp[recPtr_q] <= msCnt_q;
        recPwr[recPtr_q] <= pwr_q;
        recPre[recPtr_q] <= preAvg; // R7
        recPtr_q <= (recPtr_q == `UPW_REC_DEPTH - 1) ? 4'h0 : recPtr_q + 4'h1;
      end
    end
  end

  // ==========================================
  // info values and read port
  reg [15:0] ratio_q;
  wire [31:0] ratioRaw = (power_pickup_threshold == 24'h000000) ? 32'd25000 : pwr100 / {8'h00, power_pickup_threshold};
  wire [1:0] cond = out_d[1] ? `UPW_CND_TRIP : out_d[2] ? `UPW_CND_BLK :
    out_d[0] ? `UPW_CND_START : `UPW_CND_NORM; // R21
  // remaining time in 5 ms steps, zero when not counting
  wire [15:0] remT = (st_q == S_RUN) ? tDly - tCnt_q : 16'h0000; // R22

  always @(posedge clock) begin
    if (srst) begin
      ratio_q <= 16'h0000;
      rdData <= 32'h00000000;
    end else begin
      if (progTick) begin
        ratio_q <= (ratioRaw > 32'd25000) ? 16'd25000 : ratioRaw[15:0]; // R21
      end
      if (!rdStb) begin
        rdData <= 32'h00000000;
      end else if (addr == `UPW_A_CTRL) begin
        rdData <= ctrl_q;
      end else if (addr == `UPW_A_GIDX) begin
        rdData <= {29'h00000000, gIdx_q};
      end else if (addr == `UPW_A_PICK) begin
        rdData <= {8'h00, pickMem[gIdx_q]};
      end else if (addr == `UPW_A_INH) begin
        rdData <= {8'h00, inhMem[gIdx_q]};
      end else if (addr == `UPW_A_TDLY) begin
        rdData <= {16'h0000, tDlyMem[gIdx_q]};
      end else if (addr == `UPW_A_RDLY) begin
        rdData <= {16'h0000, rDlyMem[gIdx_q]};
      end else if (addr == `UPW_A_STAT) begin
        rdData <= {24'h000000, inhAct_q, picked_q, out_d, cond, blk_q}; // R21
      end else if (addr == `UPW_A_EXPT) begin
        rdData <= {16'h0000, instant ? 16'h0000 : tDly}; // R21
      end else if (addr == `UPW_A_REMT) begin
        rdData <= {16'h0000, remT}; // R22
      end else if (addr == `UPW_A_RATIO) begin
        rdData <= {16'h0000, ratio_q};
      end else if (addr == `UPW_A_CSTA) begin
        rdData <= cSta_q;
      end else if (addr == `UPW_A_CTRP) begin
        rdData <= cTrp_q;
      end else if (addr == `UPW_A_CBLK) begin
        rdData <= cBlk_q;
      end else if (addr == `UPW_A_PREF) begin
        rdData <= {8'h00, preAvg};
      end else if (addr == `UPW_A_TIME) begin
        rdData <= msCnt_q;
      end else if (addr == `UPW_A_RIDX) begin
        rdData <= {24'h000000, recPtr_q, recIdx_q};
      end else if (addr == `UPW_A_RSTMP) begin
        rdData <= recStamp[recIdx_q];
      end else if (addr == `UPW_A_RPWR) begin
        rdData <= {5'h00, recCode[recIdx_q], recPwr[recIdx_q]};
      end else if (addr == `UPW_A_RPRE) begin
        rdData <= {8'h00, recPre[recIdx_q]};
      end else begin
        rdData <= 32'h00000000;
      end
    end
  end
endmodule

/* File: tb/upw_stage_sva.sv */
`timescale 1ns/1ns
// ==========================================
// port checker for the stage
module upw_check #(
  parameter MS_CYC = 4,
  parameter PROG_CYC = 20
) (
  input wire clock,
  input wire srst,
  input wire [4:0] addr,
  input wire [31:0] wrData,
  input wire wrStb,
  input wire rdStb,
  input wire [31:0] rdData,
  input wire [23:0] measuredPower,
  input wire [2:0] activeGroup,
  input wire blockIn,
  input wire measSide,
  input wire startOut,
  input wire tripOut,
  input wire blockedOut,
  input wire [2:0] evOn,
  input wire [2:0] evOff,
  input wire [31:0] evStamp,
  input wire [23:0] evPower,
  input wire displayEvent
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  // ==========================================
  // event steps
  sequence sStartEv;
    ##[0:1] evOn[0];
  endsequence
  sequence sBlkEv;
    ##[0:1] (evOn[2] && displayEvent);
  endsequence
  // ==========================================
  // assertions
  a_start_event: assert property ($rose(startOut) |-> sStartEv)
    else $error("start rose without its event");
  a_block_display: assert property ($rose(blockedOut) |-> sBlkEv)
    else $error("blocked rose without display event");
  a_trip_off: assert property ($fell(tripOut) |-> ##[0:1] evOff[1])
    else $error("trip fell without off event");
  a_event_pulse: assert property (|evOn |=> evOn == 3'h0)
    else $error("on event longer than one cycle");
  a_read_idle: assert property (!rdStb |=> rdData == 32'h0)
    else $error("read data outside read cycle");
  // start, trip and blocked outputs only move at program ticks, so they stand for many cycles
  a_out_stand: assert property ($changed(startOut) |=> $stable(startOut)[*8])
    else $error("start changed between ticks");
  a_stamp_hold: assert property ($changed(evStamp) |-> (|evOn) || (|evOff))
    else $error("stamp moved without event");
  a_reset_clear: assert property ($fell(srst) |-> !startOut && !tripOut && !blockedOut)
    else $error("outputs not clear after reset");
endmodule
bind upw_stage upw_check #(.MS_CYC(MS_CYC), .PROG_CYC(PROG_CYC)) chk (
  .clock(clock), .srst(srst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
  .rdStb(rdStb), .rdData(rdData), .measuredPower(measuredPower),
  .activeGroup(activeGroup), .blockIn(blockIn), .measSide(measSide),
  .startOut(startOut), .tripOut(tripOut), .blockedOut(blockedOut), .evOn(evOn),
  .evOff(evOff), .evStamp(evStamp), .evPower(evPower), .displayEvent(displayEvent)
);

/* File: tb/upw_power_src.sv */
`timescale 1ns/1ns
// ==========================================
// power chain and blocking matrix stand-in
module upw_power_src (
  input wire clock,
  input wire measSide,
  input wire [23:0] powA,
  input wire [23:0] powB,
  input wire blkReq,
  output reg [23:0] measuredPower,
  output reg blockIn
);
  initial begin
    measuredPower = 24'h0;
    blockIn = 1'b0;
  end
  // refreshed each clock; the stage itself decides when to sample
  always @(posedge clock) begin
    measuredPower <= measSide ? powB : powA;
    blockIn <= blkReq;
  end
endmodule

/* File: tb/test_upw_stage.sv */
`timescale 1ns/1ns
`include "upw_map.vh"
module test_upw_stage;
  typedef struct {logic w; logic [4:0] a; logic [31:0] d; logic [31:0] e;} upw_row_t;
  localparam int PC = 20;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [4:0] addr = 5'h0;
  logic [31:0] wrData = 32'h0;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic [23:0] powA = 24'h0;
  logic blkReq = 1'b0;
  wire [31:0] rdData;
  wire [23:0] measuredPower;
  wire blockIn;
  wire measSide;
  wire startOut;
  wire tripOut;
  wire blockedOut;
  wire [2:0] evOn;
  wire [2:0] evOff;
  wire [31:0] evStamp;
  wire [23:0] evPower;
  wire displayEvent;
  logic [31:0] v;
  logic [31:0] stS;
  logic [31:0] stT;
  logic [23:0] blkPow;
  int n;
  int nOff = 0;
  int nDisp = 0;
  int fail_count = 0;
  int comparisons = 0;
  upw_row_t rows [0:7] = '{
    '{1'h0, `UPW_A_STAT, 32'h0, 32'h80}, '{1'h0, `UPW_A_CTRL, 32'h0, 32'h1},
    '{1'h0, `UPW_A_PICK, 32'h0, 32'h2710}, '{1'h0, `UPW_A_INH, 32'h0, 32'h1388},
    '{1'h0, `UPW_A_TDLY, 32'h0, 32'h14}, '{1'h0, `UPW_A_RDLY, 32'h0, 32'h0},
    '{1'h1, 5'h1f, 32'h5, 32'h0}, '{1'h1, `UPW_A_TDLY, 32'h3, 32'h3}};
  always #50 clock = ~clock;
  upw_stage #(.MS_CYC(4), .PROG_CYC(PC)) dut (
    .clock(clock), .srst(srst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData(rdData), .measuredPower(measuredPower),
    .activeGroup(3'h0), .blockIn(blockIn), .measSide(measSide),
    .startOut(startOut), .tripOut(tripOut), .blockedOut(blockedOut), .evOn(evOn),
    .evOff(evOff), .evStamp(evStamp), .evPower(evPower), .displayEvent(displayEvent));
  upw_power_src src (.clock(clock), .measSide(measSide), .powA(powA), .powB(powA),
    .blkReq(blkReq), .measuredPower(measuredPower), .blockIn(blockIn));
  // ==========================================
  // event capture
  always @(posedge clock) begin
    if (evOn[0]) stS = evStamp;
    if (evOn[1]) stT = evStamp;
    if (evOn[2]) blkPow = evPower;
    nOff += evOff[1];
    nDisp += displayEvent;
  end
  // ==========================================
  // tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clock);
    wrStb <= 1'b0;
  endtask
  task rdc(input logic [4:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clock);
    rdStb <= 1'b0;
    #1 chk(rdData, e);
  endtask
  task setP(input logic [23:0] p, input logic b);
    @(posedge clock);
    powA <= p;
    blkReq <= b;
  endtask
  // bounded wait; outputs only move on ticks, so a few ticks is plenty
  task waitOut(input int i, input logic x, output int k);
    logic [2:0] o;
    k = 0;
    o = {blockedOut, tripOut, startOut};
    while (o[i] !== x && k < 200) begin
      @(posedge clock);
      #1 o = {blockedOut, tripOut, startOut};
      k++;
    end
    chk({31'h0, o[i]}, {31'h0, x});
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    end_sim;
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    foreach (rows[k]) begin
      if (rows[k].w) wr(rows[k].a, rows[k].d);
      rdc(rows[k].a, rows[k].e);
    end
    wr(`UPW_A_CTRL, 32'h9);
    @(posedge clock);
    #1 chk({31'h0, measSide}, 32'h1);
    wr(`UPW_A_CTRL, 32'h1);
    $display("register test done");
    setP(24'h2328, 1'b0);
    repeat (3 * PC) @(posedge clock);
    #1 chk({31'h0, startOut}, 32'h0);
    $display("inhibit test done");
    setP(24'h2af8, 1'b0);
    repeat (2 * PC) @(posedge clock);
    setP(24'h2328, 1'b0);
    waitOut(0, 1'b1, n);
    waitOut(1, 1'b1, n);
    chk(n, 3 * PC);
    rdc(`UPW_A_STAT, 32'h5c);
    rdc(`UPW_A_EXPT, 32'h3);
    rdc(`UPW_A_CTRP, 32'h1);
    $display("delayed trip test done");
    setP(24'h27d8, 1'b0);
    repeat (3 * PC) @(posedge clock);
    #1 chk({31'h0, startOut}, 32'h1);
    setP(24'h28a0, 1'b0);
    waitOut(0, 1'b0, n);
    chk({31'h0, tripOut}, 32'h0);
    chk(nOff, 1);
    rdc(`UPW_A_RATIO, 32'h68);
    $display("release test done");
    wr(`UPW_A_CTRL, 32'h0);
    setP(24'h2328, 1'b0);
    waitOut(1, 1'b1, n);
    repeat (2) @(posedge clock);
    chk(stT, stS);
    setP(24'h2af8, 1'b0);
    waitOut(0, 1'b0, n);
    wr(`UPW_A_CTRL, 32'h1);
    $display("instant test done");
    setP(24'h2328, 1'b0);
    waitOut(0, 1'b1, n);
    setP(24'h2328, 1'b1);
    waitOut(0, 1'b0, n);
    waitOut(2, 1'b1, n);
    repeat (2) @(posedge clock);
    chk({31'h0, tripOut}, 32'h0);
    chk(nDisp, 1);
    chk({8'h0, blkPow}, 32'h2328);
    setP(24'h2af8, 1'b1);
    waitOut(2, 1'b0, n);
    repeat (2 * PC) @(posedge clock);
    setP(24'h2328, 1'b1);
    waitOut(2, 1'b1, n);
    repeat (4 * PC) @(posedge clock);
    #1 chk({31'h0, startOut}, 32'h0);
    setP(24'h2af8, 1'b0);
    waitOut(2, 1'b0, n);
    $display("blocking test done");
    rdc(`UPW_A_CBLK, 32'h2);
    wr(`UPW_A_CCLR, 32'h7);
    rdc(`UPW_A_CSTA, 32'h0);
    rdc(`UPW_A_CBLK, 32'h0);
    $display("counter test done");
    wr(`UPW_A_CTRL, 32'h23);
    waitOut(1, 1'b1, n);
    wr(`UPW_A_CTRL, 32'h1);
    waitOut(1, 1'b0, n);
    $display("forcing test done");
    end_sim;
  end
endmodule
